// File: common/ipc_pkg.sv
// Purpose: shared constants and types of the interrupt level/sense block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   byte offsets below are the word addresses seen on haddr
package ipc_pkg;
    localparam int NUM_LINES = 6;
    localparam int NUM_LEVEL_REGS = 10;
    localparam int LEVEL_W = 3;
    localparam int IDX_W = 4;
    localparam int UPPER_LSB = 4;
    localparam int LOWER_LSB = 0;
    localparam int OFS_W = 8;

    // register map, byte addresses
    localparam logic [7:0] OFS_LEVEL_BASE = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h28;
    localparam logic [7:0] OFS_SENSE_LOW = 8'h2C;
    localparam logic [7:0] OFS_SENSE_HIGH = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h38;
    localparam logic [7:0] OFS_EVT_MASK = 8'h3C;

    // reset values and writable masks
    localparam logic [7:0] LEVEL_RESET = 8'h77;
    localparam logic [7:0] LEVEL_MASK = 8'h77;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] SENSE_RESET = 8'h00;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [3:0] NMI_LEVEL = 4'h8;
    localparam logic [3:0] IDX_NONE = 4'hF;

    // sense select encodings
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_FALL = 2'b01,
        SENSE_RISE = 2'b10,
        SENSE_BOTH = 2'b11
    } ipc_sense_e;

    // line to level field map: register index and upper/lower field
    localparam logic [3:0] LINE_REG [NUM_LINES] =
        '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1};
    localparam logic LINE_UPPER [NUM_LINES] =
        '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
endpackage

// File: common/ipc_mem_if.sv
`timescale 1ns/10ps
// Purpose: carrier between register decode and the level register store
// Assumes: single clock, used only inside the block
// Notes:   level_a and level_b expose the two registers that feed the lines
interface ipc_mem_if;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic [3:0] rd_idx;
    logic [7:0] rd_data;
    logic [7:0] level_a;
    logic [7:0] level_b;
    modport ctrl (output wr_en, wr_idx, wr_data, rd_idx,
                  input rd_data, level_a, level_b);
    modport mem (input wr_en, wr_idx, wr_data, rd_idx,
                 output rd_data, level_a, level_b);
endinterface // ipc_mem_if

// File: hw/ipc_level_mem.sv
`timescale 1ns/10ps
// Purpose: store of the ten source level registers, registered read port
// Assumes: rd_idx is presented in the address phase of a read
// Notes:   write bypass keeps back-to-back write then read coherent
module ipc_level_mem (
    input wire logic hclk,
    input wire logic hresetn,
    ipc_mem_if.mem mif
);
    logic [7:0] level_regs [ipc_pkg::NUM_LEVEL_REGS];
    logic [7:0] next_rd;
    logic wr_ok;
    logic rd_ok;

    // ---------------------------------------------------------------
    // index checks
    // ---------------------------------------------------------------
    assign wr_ok = mif.wr_en
        && (mif.wr_idx < 4'(ipc_pkg::NUM_LEVEL_REGS));
    assign rd_ok = mif.rd_idx < 4'(ipc_pkg::NUM_LEVEL_REGS);
    assign mif.level_a = level_regs[0];
    assign mif.level_b = level_regs[1];

    // read mux with bypass of a write in the same cycle
    always_comb
    begin
        next_rd = 8'h00;
        if (wr_ok && mif.wr_idx == mif.rd_idx)
            next_rd = mif.wr_data & ipc_pkg::LEVEL_MASK;
        else if (rd_ok)
            next_rd = level_regs[mif.rd_idx];
    end

    // storage: reserved bits 7 and 3 never hold a one
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < ipc_pkg::NUM_LEVEL_REGS; i++)
                level_regs[i] <= ipc_pkg::LEVEL_RESET;
            mif.rd_data <= 8'h00;
        end
        else
        begin
            if (wr_ok)
                level_regs[mif.wr_idx] <= mif.wr_data
                    & ipc_pkg::LEVEL_MASK;
            mif.rd_data <= next_rd;
        end
    end
endmodule // ipc_level_mem

// File: hw/ipc_top.sv
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
// Purpose: programmable levels, line enables, sense control, line flags
// Assumes: line pins asynchronous; accept and nmi select on hclk
// Notes:   AHB-Lite slave with zero wait states, always OKAY

// Contract
// - ten 8-bit readable writable level registers
// - two 3-bit level fields, bits 2:0, 6:4
// - level field is unsigned, 7 highest
// - bits 7 and 3 read zero, ignore writes
// - level fields reset to all ones
// - enable bit n permits line n, resets 0
// - line n sense select at bits 2n+1:2n
// - 00 low, 01 fall, 10 rise, 11 both
// - sense bits reset 0, read writable
// - flag set on detect, read-one-write-zero clears
// - exception handling clears flag, level needs high
// - nmi fixed level 8, always accepted
// - equal levels: lower vector number wins
module ipc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [5:0] line_pin,
    input wire logic nmi_pin,
    input wire logic nmi_rising_sel,
    input wire logic [5:0] accept_line,
    output logic [5:0] line_req,
    output logic [17:0] line_level,
    output logic nmi_req,
    output logic win_valid,
    output logic win_nmi,
    output logic [2:0] win_line,
    output logic [3:0] win_level,
    output logic irq
);
    localparam int N = ipc_pkg::NUM_LINES;

    ipc_mem_if mif ();

    logic [7:0] ext_line_enable;
    logic [7:0] ext_line_sense_low;
    logic [7:0] ext_line_sense_high;
    logic [5:0] line_request_flag;
    logic [5:0] read_seen;
    logic [5:0] evt_status;
    logic [5:0] evt_mask;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] pin_prev;
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_prev;
    logic [7:0] dp_addr;
    logic dp_write;
    logic dp_read;
    logic dp_mem;
    logic [7:0] rdata_q;
    logic [5:0] detect;
    logic [5:0] next_flag;
    logic [5:0] next_seen;
    logic [15:0] sense_pair;
    logic [7:0] rd_mux;
    logic [2:0] lvl [N];
    logic [2:0] best_lvl;
    logic [2:0] best_line;
    logic best_found;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // word offset to level register index, IDX_NONE when outside
    function automatic logic [3:0] level_idx(input logic [7:0] a);
        logic [7:0] w;
        w = (a - ipc_pkg::OFS_LEVEL_BASE) >> 2;
        if (a >= ipc_pkg::OFS_LEVEL_BASE
            && w < 8'(ipc_pkg::NUM_LEVEL_REGS))
            return w[3:0];
        return ipc_pkg::IDX_NONE;
    endfunction

    // pick the upper or lower level field of a register
    function automatic logic [2:0] field(input logic [7:0] r,
                                         input logic upper);
        return upper ? r[ipc_pkg::UPPER_LSB +: ipc_pkg::LEVEL_W]
                     : r[ipc_pkg::LOWER_LSB +: ipc_pkg::LEVEL_W];
    endfunction

    // ---------------------------------------------------------------
    // bus address phase decode
    // ---------------------------------------------------------------
    logic ap_valid;
    logic [7:0] ap_addr;
    logic [3:0] ap_idx;
    logic [3:0] dp_idx;
    assign ap_valid = hsel && htrans[1] && hready;
    assign ap_addr = haddr[7:0];
    assign ap_idx = (haddr[31:8] == 24'h00_0000)
        ? level_idx(ap_addr) : ipc_pkg::IDX_NONE;
    assign dp_idx = level_idx(dp_addr);
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0;
    // hsize ignored: only whole-word transfers are supported

    // the level store reads on the address phase, writes on data phase
    assign mif.rd_idx = ap_idx;
    assign mif.wr_en = dp_write && dp_idx != ipc_pkg::IDX_NONE;
    assign mif.wr_idx = dp_idx;
    assign mif.wr_data = hwdata[7:0];

    // address phase capture; unmapped high addresses decode to none
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_addr <= 8'h00;
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_mem <= 1'b0;
        end
        else
        begin
            dp_addr <= (haddr[31:8] == 24'h00_0000) ? ap_addr
                                                    : 8'hFF;
            dp_write <= ap_valid && hwrite;
            dp_read <= ap_valid && !hwrite;
            dp_mem <= ap_idx != ipc_pkg::IDX_NONE;
        end
    end

    // ---------------------------------------------------------------
    // read data for the registers held here
    // ---------------------------------------------------------------
    // reserved status bits and unmapped words read as zero
    always_comb
    begin
        rd_mux = 8'h00;
        if (haddr[31:8] == 24'h00_0000)
        begin
            case (ap_addr)
                ipc_pkg::OFS_ENABLE: rd_mux = ext_line_enable;
                ipc_pkg::OFS_SENSE_LOW: rd_mux = ext_line_sense_low;
                ipc_pkg::OFS_SENSE_HIGH: rd_mux = ext_line_sense_high;
                ipc_pkg::OFS_STATUS: rd_mux = {2'b00, line_request_flag};
                ipc_pkg::OFS_EVT_STATUS: rd_mux = {2'b00, evt_status};
                ipc_pkg::OFS_EVT_MASK: rd_mux = {2'b00, evt_mask};
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 8'h00;
        else if (ap_valid && !hwrite)
            rdata_q <= rd_mux;
    end

    assign hrdata = {24'h00_0000, dp_mem ? mif.rd_data : rdata_q};

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    // reserved bits of enable and sense are plain storage; software keeps them zero; evt_mask keeps bits 5:0 only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_line_enable <= ipc_pkg::ENABLE_RESET;
            ext_line_sense_low <= ipc_pkg::SENSE_RESET;
            ext_line_sense_high <= ipc_pkg::SENSE_RESET;
            evt_mask <= 6'h00;
        end
        else if (dp_write)
        begin
            case (dp_addr)
                ipc_pkg::OFS_ENABLE: ext_line_enable <= hwdata[7:0];
                ipc_pkg::OFS_SENSE_LOW:
                    ext_line_sense_low <= hwdata[7:0];
                ipc_pkg::OFS_SENSE_HIGH:
                    ext_line_sense_high <= hwdata[7:0];
                ipc_pkg::OFS_EVT_MASK: evt_mask <= hwdata[5:0];
                default: ;
            endcase
        end
    end

    assign sense_pair = {ext_line_sense_high, ext_line_sense_low};

    // ---------------------------------------------------------------
    // pin synchronisers and edge history
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta <= 6'h3F;
            pin_sync <= 6'h3F;
            pin_prev <= 6'h3F;
            nmi_meta <= 1'b1;
            nmi_sync <= 1'b1;
            nmi_prev <= 1'b1;
        end
        else
        begin
            pin_meta <= line_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            nmi_meta <= nmi_pin;
            nmi_sync <= nmi_meta;
            nmi_prev <= nmi_sync;
        end
    end

    // ---------------------------------------------------------------
    // per-line detection and flag update
    // ---------------------------------------------------------------
    // set beats clear so an event in the clearing cycle is kept
    always_comb
    begin
        next_flag = line_request_flag;
        next_seen = read_seen;
        for (int i = 0; i < N; i++)
        begin
            case (ipc_pkg::ipc_sense_e'(sense_pair[2*i +: 2]))
                ipc_pkg::SENSE_LOW_LEVEL: detect[i] = !pin_sync[i];
                ipc_pkg::SENSE_FALL:
                    detect[i] = pin_prev[i] && !pin_sync[i];
                ipc_pkg::SENSE_RISE:
                    detect[i] = !pin_prev[i] && pin_sync[i];
                ipc_pkg::SENSE_BOTH:
                    detect[i] = pin_prev[i] != pin_sync[i];
                default: detect[i] = 1'b0;
            endcase
            // a read that returns one arms the software clear
            if (dp_read && dp_addr == ipc_pkg::OFS_STATUS
                && rdata_q[i])
                next_seen[i] = 1'b1;
            if (dp_write && dp_addr == ipc_pkg::OFS_STATUS
                && read_seen[i] && !hwdata[i])
            begin
                next_flag[i] = 1'b0;
                next_seen[i] = 1'b0;
            end
            if (accept_line[i]
                && (sense_pair[2*i +: 2] != ipc_pkg::SENSE_LOW_LEVEL
                    || pin_sync[i]))
                next_flag[i] = 1'b0;
            if (detect[i])
                next_flag[i] = 1'b1;
            if (!next_flag[i])
                next_seen[i] = 1'b0;
        end
    end

    // event sticky bits follow detection, writing one clears them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_request_flag <= ipc_pkg::FLAGS_RESET;
            read_seen <= 6'h00;
            evt_status <= 6'h00;
        end
        else
        begin
            line_request_flag <= next_flag;
            read_seen <= next_seen;
            if (dp_write && dp_addr == ipc_pkg::OFS_EVT_STATUS)
                evt_status <= (evt_status & ~hwdata[5:0]) | detect;
            else
                evt_status <= evt_status | detect;
        end
    end

    assign irq = |(evt_status & evt_mask);

    // ---------------------------------------------------------------
    // request outputs and level tagging
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_line
            assign lvl[g] = field(ipc_pkg::LINE_REG[g] == 4'h0
                ? mif.level_a : mif.level_b,
                ipc_pkg::LINE_UPPER[g]);
            assign line_req[g] = line_request_flag[g]
                && ext_line_enable[g];
            assign line_level[3*g +: 3] = lvl[g];
        end
    endgenerate

    // ---------------------------------------------------------------
    // arbitration between pending lines
    // ---------------------------------------------------------------
    // strict greater keeps the lower line, which has the lower vector
    always_comb
    begin
        best_found = 1'b0;
        best_lvl = 3'h0;
        best_line = 3'h0;
        for (int i = 0; i < N; i++)
        begin
            if (line_req[i] && (!best_found || lvl[i] > best_lvl))
            begin
                best_found = 1'b1;
                best_lvl = lvl[i];
                best_line = 3'(i);
            end
        end
    end

    // nmi edge detect; its level sits above every field value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            nmi_req <= 1'b0;
        else
            nmi_req <= nmi_rising_sel ? (!nmi_prev && nmi_sync)
                                      : (nmi_prev && !nmi_sync);
    end

    assign win_nmi = nmi_req;
    assign win_valid = nmi_req || best_found;
    assign win_line = best_line;
    assign win_level = nmi_req ? ipc_pkg::NMI_LEVEL
                               : {1'b0, best_lvl};

    ipc_level_mem u_mem (
        .hclk (hclk),
        .hresetn (hresetn),
        .mif (mif)
    );
endmodule // ipc_top

// File: bench/ipc_monitor.sv
// Purpose: port checks of the level/sense block
// Assumes: one clock, zero-wait bus slave
// Notes:   helper flops track read phases and enable writes
`timescale 1ns/10ps
module ipc_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [5:0] line_req,
    input wire logic [17:0] line_level,
    input wire logic nmi_req,
    input wire logic win_valid,
    input wire logic win_nmi,
    input wire logic [2:0] win_line,
    input wire logic [3:0] win_level
);
    logic rd_dp;
    logic en_wr;
    logic [31:0] rd_a;
    logic [31:0] wd_q;
    logic [2:0] best_l;
    logic [2:0] best_n;
    wire take = hsel && htrans[1] && hready;
    wire en_hit = haddr == {24'h00_0000, ipc_pkg::OFS_ENABLE};
    // phase tracking; en_wr sticks until reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_dp <= 1'b0;
            en_wr <= 1'b0;
            rd_a <= 32'h0000_0000;
            wd_q <= 32'h0000_0000;
        end
        else
        begin
            rd_dp <= take && !hwrite;
            en_wr <= en_wr || (take && hwrite && en_hit);
            rd_a <= haddr;
            wd_q <= hwdata;
        end
    end
    // reference winner: scan down, ties go to the lower line
    always_comb
    begin
        best_l = 3'h0;
        best_n = 3'h0;
        for (int i = 5; i >= 0; i--)
            if (line_req[i] && line_level[3*i+:3] >= best_l)
            begin
                best_l = line_level[3*i+:3];
                best_n = 3'(i);
            end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_wr_a;
        take && hwrite && haddr == 32'h0000_0000;
    endsequence
    sequence s_rd_lvl;
        rd_dp && rd_a < 32'h0000_0028;
    endsequence
    a_level_reset: assert property (
        $rose(hresetn) |-> line_level == 18'h3_FFFF)
        else $error("levels not 7 after reset");
    a_level_map: assert property (
        rd_dp && rd_a == 32'h0000_0000 |->
        hrdata[6:4] == line_level[2:0] && hrdata[2:0] == line_level[5:3])
        else $error("reg a fields differ");
    a_reserved_zero: assert property (
        s_rd_lvl |-> hrdata[7] == 1'b0 && hrdata[3] == 1'b0
        && hrdata[31:8] == 24'h00_0000)
        else $error("reserved bits nonzero");
    a_write_lands: assert property (
        s_wr_a ##1 1'b1 |=> line_level[2:0] == wd_q[6:4]
        && line_level[5:3] == wd_q[2:0])
        else $error("level write lost");
    a_req_gated: assert property (
        !en_wr |-> line_req == 6'h00)
        else $error("request while disabled");
    a_win_valid: assert property (
        win_valid == (nmi_req || line_req != 6'h00))
        else $error("bad winner valid");
    a_win_order: assert property (
        win_valid && !win_nmi |-> win_line == best_n
        && win_level == {1'b0, best_l})
        else $error("bad winner");
    a_nmi_level: assert property (
        nmi_req |-> win_valid && win_nmi && win_level == 4'h8)
        else $error("bad nmi level");
    a_nmi_pulse: assert property (
        nmi_req |=> !nmi_req)
        else $error("long nmi pulse");
endmodule // ipc_monitor

// File: bench/ipc_pin_model.sv
// Purpose: external pins and cpu acceptance around the block
// Assumes: pins idle high, set by the bench
// Notes:   ack_wait sets how slowly the cpu takes the winner
`timescale 1ns/10ps
module ipc_pin_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [5:0] pin_cmd,
    input wire logic nmi_cmd,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic win_valid,
    input wire logic win_nmi,
    input wire logic [2:0] win_line,
    output logic [5:0] line_pin,
    output logic nmi_pin,
    output logic [5:0] accept_line
);
    logic [3:0] cnt;
    // pins follow one cycle late; accept is a one-cycle pulse
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_pin <= 6'h3F;
            nmi_pin <= 1'b1;
            accept_line <= 6'h00;
            cnt <= 4'h0;
        end
        else
        begin
            line_pin <= pin_cmd;
            nmi_pin <= nmi_cmd;
            accept_line <= 6'h00;
            if (accept_line != 6'h00 || !(ack_en && win_valid && !win_nmi))
                cnt <= 4'h0;
            else if (cnt == ack_wait)
                accept_line <= 6'h01 << win_line;
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule // ipc_pin_model

// File: bench/test_irq_priority_sense_enable_regs.sv
// Purpose: self-checking bench of the level/sense block
// Assumes: results are scored in order from one queue
// Notes:   expectations come from the map and the pins
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module test_irq_priority_sense_enable_regs;
    localparam logic [7:0] STA = ipc_pkg::OFS_STATUS;
    localparam logic [7:0] EVS = ipc_pkg::OFS_EVT_STATUS;
    localparam logic [7:0] EVM = ipc_pkg::OFS_EVT_MASK;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rdp = 1'b0;
    logic obp = 1'b0;
    logic ack_en = 1'b0;
    logic nmi_cmd = 1'b1;
    logic rise_sel = 1'b1;
    logic [1:0] htrans = 2'b00;
    logic [5:0] pin_cmd = 6'h3F;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] seed = 32'h0001_6266;
    logic [31:0] got;
    logic [31:0] d;
    logic [31:0] ev;
    logic [31:0] q[$];
    logic hreadyout, hresp, nmi_pin, nmi_req, win_valid, win_nmi, irq;
    logic [31:0] hrdata;
    logic [5:0] line_pin, accept_line, line_req;
    logic [17:0] line_level;
    logic [2:0] win_line;
    logic [3:0] win_level;
    int fails = 0;
    int tests_run = 0;
    wire [31:0] obs_v = {15'h0000, hresp, irq, win_valid, win_nmi, win_line,
                         win_level, line_req};
    always #10 hclk = ~hclk;
    ipc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .line_pin(line_pin),
        .nmi_pin(nmi_pin), .nmi_rising_sel(rise_sel),
        .accept_line(accept_line), .line_req(line_req),
        .line_level(line_level), .nmi_req(nmi_req), .win_valid(win_valid),
        .win_nmi(win_nmi), .win_line(win_line), .win_level(win_level),
        .irq(irq));
    ipc_pin_model u_pins (.hclk(hclk), .hresetn(hresetn),
        .pin_cmd(pin_cmd), .nmi_cmd(nmi_cmd), .ack_en(ack_en),
        .ack_wait(4'h3), .win_valid(win_valid), .win_nmi(win_nmi),
        .win_line(win_line), .line_pin(line_pin), .nmi_pin(nmi_pin),
        .accept_line(accept_line));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ov(input logic i, input logic [2:0] w,
        input logic [3:0] l, input logic [5:0] r);
        return {16'h0000, i, r != 6'h00, 1'b0, w, l, r};
    endfunction
    // single transfer, held until hready high
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] dat, input logic [31:0] e);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? dat : rnd();
        rdp <= !w;
        if (!w)
            q.push_back(e);
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rdp <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        bus(1'b1, a, dat, 32'h0000_0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, e);
    endtask
    // idle cycle keeps obp pulses apart
    task automatic obs(input logic [31:0] e);
        q.push_back(e);
        obp <= 1'b1;
        @(posedge hclk);
        obp <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic pins(input logic [5:0] p, input logic n);
        pin_cmd <= p;
        nmi_cmd <= n;
        repeat (8) @(posedge hclk);
    endtask
    task automatic wrap_up();
        if (q.size() != 0)
            fails++;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // scorer: notes taken in issue order
    always @(posedge hclk)
    begin
        if (rdp || obp || nmi_req === 1'b1)
        begin
            got = rdp ? hrdata : obp ? obs_v : {28'h000_0000, win_level};
            ev = (q.size() == 0) ? 32'hFFFF_FFFF : q.pop_front();
            `CHK(got, ev)
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 10; i++)
            rd(8'(4 * i), 32'h0000_0077);
        rd(ipc_pkg::OFS_ENABLE, 32'h0000_0000);
        rd(ipc_pkg::OFS_SENSE_LOW, 32'h0000_0000);
        rd(ipc_pkg::OFS_SENSE_HIGH, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        for (int i = 0; i < 10; i++)
        begin
            d = rnd();
            wr(8'(4 * i), d);
            rd(8'(4 * i), d & 32'h0000_0077);
        end
        wr(8'h00, 32'h0000_00FF);
        rd(8'h00, 32'h0000_0077);
        // line0 low, line1 fall, line2 rise, line3 both, 4 fall, 5 rise
        wr(ipc_pkg::OFS_SENSE_LOW, 32'h0000_00E4);
        wr(ipc_pkg::OFS_SENSE_HIGH, 32'h0000_0009);
        rd(ipc_pkg::OFS_SENSE_LOW, 32'h0000_00E4);
        rd(ipc_pkg::OFS_SENSE_HIGH, 32'h0000_0009);
        wr(8'h00, 32'h0000_0025);
        wr(8'h04, 32'h0000_0061);
        pins(6'h30, 1'b1);
        rd(STA, 32'h0000_000B);
        obs(ov(1'b0, 3'h0, 4'h0, 6'h00));
        pins(6'h3F, 1'b1);
        rd(STA, 32'h0000_000F);
        wr(ipc_pkg::OFS_ENABLE, 32'h0000_003F);
        obs(ov(1'b0, 3'h2, 4'h6, 6'h0F));
        wr(STA, 32'h0000_000B);
        rd(STA, 32'h0000_000B);
        ack_en <= 1'b1;
        repeat (30) @(posedge hclk);
        ack_en <= 1'b0;
        rd(STA, 32'h0000_0000);
        pins(6'h2F, 1'b1);
        wr(STA, 32'h0000_0000);
        obs(ov(1'b0, 3'h4, 4'h1, 6'h10));
        rd(STA, 32'h0000_0010);
        wr(STA, 32'h0000_0000);
        rd(STA, 32'h0000_0000);
        pins(6'h3F, 1'b1);
        // sticky events: raise, mask, clear
        wr(EVS, 32'h0000_003F);
        rd(EVS, 32'h0000_0000);
        pins(6'h37, 1'b1);
        pins(6'h3F, 1'b1);
        obs(ov(1'b0, 3'h3, 4'h6, 6'h08));
        wr(EVM, 32'h0000_0008);
        obs(ov(1'b1, 3'h3, 4'h6, 6'h08));
        wr(EVS, 32'h0000_0008);
        obs(ov(1'b0, 3'h3, 4'h6, 6'h08));
        // nmi: wrong edge ignored, then each select
        pins(6'h3F, 1'b0);
        q.push_back(32'h0000_0008);
        pins(6'h3F, 1'b1);
        rise_sel <= 1'b0;
        @(posedge hclk);
        q.push_back(32'h0000_0008);
        pins(6'h3F, 1'b0);
        wrap_up();
    end
    // hang guard, well above the run's length
    initial
    begin
        repeat (5000) @(posedge hclk);
        fails++;
        wrap_up();
    end
endmodule // test_irq_priority_sense_enable_regs
bind ipc_top ipc_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .line_req(line_req), .line_level(line_level), .nmi_req(nmi_req),
    .win_valid(win_valid), .win_nmi(win_nmi), .win_line(win_line),
    .win_level(win_level));
